// ==== rtl/frs_ref_select.v ====
// frequency reference source select for a motor drive
// assumes register accesses arrive as one-cycle strobes from the serial
// protocol engine, and all terminal values are synchronous to sys_clk;
// step table and terminal settings are static levels, and the pulse
// reference trails the pin by up to one gate plus the divide
//
// Function
// RL1 - source code picks panel, analog, comm, option, pulse
// RL2 - source resets to analog, locked while running
// RL3 - code 0 uses operator panel frequency
// RL4 - code 1 uses first or second analog
// RL5 - host sets current-only master input config
// RL6 - aux input on third analog when step1 on
// RL7 - host configures third analog as auxiliary
// RL8 - code 4 uses pulse train input
// RL9 - pulse function 0..2, resets 0, locked running
// RL10 - pulse scaling 1000..32000 Hz, resets 1440
// RL11 - seventeen steps: sixteen stored plus jog
// RL12 - jog selection overrides multi-step inputs
// RL13 - out-of-range writes rejected, value kept
`timescale 1ns/10ps
`include "frs_defines.vh"

module frs_ref_select
#(
    parameter GATE_CYCLES = `FRS_GATE_MS * `FRS_CLK_KHZ,
    parameter STEPS       = `FRS_STORED_STEPS
)
(
    // clock and reset
    input  wire                sys_clk,
    input  wire                rst,
    // register access from the serial protocol engine
    input  wire                reg_wr,
    input  wire                reg_rd,
    input  wire [15:0]         reg_addr,
    input  wire [15:0]         reg_wdata,
    output reg  [15:0]         reg_rdata,
    output reg                 reg_ack,
    output reg                 reg_err,
    // drive state
    input  wire                drive_running,
    // reference sources
    input  wire [15:0]         panel_freq,
    input  wire [15:0]         first_analog_terminal,
    input  wire [15:0]         second_analog_terminal,
    input  wire [15:0]         third_analog_terminal,
    input  wire [15:0]         comm_freq,
    input  wire [15:0]         option_freq,
    input  wire                pulse_input_terminal,
    // analog terminal configuration
    input  wire [1:0]          second_analog_level_select,
    input  wire [4:0]          second_analog_function_select,
    input  wire [4:0]          third_analog_function_select,
    // multi-step and jog selection
    input  wire [3:0]          multi_step_in,
    input  wire                jog_select,
    input  wire [16*STEPS-1:0] stored_refs,
    input  wire [15:0]         jog_ref,
    // results
    output reg  [15:0]         freq_ref,
    output reg  [4:0]          active_step,
    output reg  [15:0]         pid_feedback,
    output reg  [15:0]         pid_target,
    output reg                 a2_current_mode
);

    // settings
    reg  [15:0] reference_source_select;
    reg  [15:0] pulse_input_function_select;
    reg  [15:0] pulse_input_full_scale;

    // selection path
    reg  [15:0] next_freq_ref;
    reg  [15:0] base_ref;
    reg  [4:0]  next_step;
    reg  [16:0] analog_sum;
    reg  [15:0] analog_ref;
    wire [15:0] stored_ref [0:STEPS-1];

    // pulse measurement
    wire [15:0] pulse_pct;
    wire        pct_valid;

    // register decode and write admission
    wire        hit_src;
    wire        hit_pfunc;
    wire        hit_pscale;
    wire        src_ok;
    wire        pfunc_ok;
    wire        pscale_ok;
    wire        wr_src;
    wire        wr_pfunc;
    wire        wr_pscale;

    // unpack the stored step table, one entry per step
    // entry zero is never picked: step code zero means the master source
    genvar gi;
    generate
        for (gi = 0; gi < STEPS; gi = gi + 1)
        begin : g_unpack
            assign stored_ref[gi] = stored_refs[16*gi +: 16]; // RL11
        end
    endgenerate

    // address decode
    // full compare on purpose: a partial decode would alias stray
    // writes aimed at other drive settings onto these three
    assign hit_src    = (reg_addr == `FRS_ADDR_SRC);
    assign hit_pfunc  = (reg_addr == `FRS_ADDR_PFUNC);
    assign hit_pscale = (reg_addr == `FRS_ADDR_PSCALE);

    // write admission: range and running lockouts
    // scaling stays writable while running so speed can be trimmed live
    assign src_ok    = (reg_wdata <= `FRS_SRC_MAX) && !drive_running; // RL2
    assign pfunc_ok  = (reg_wdata <= `FRS_PFUNC_MAX)
                       && !drive_running; // RL9
    assign pscale_ok = (reg_wdata >= `FRS_PSCALE_MIN)
                       && (reg_wdata <= `FRS_PSCALE_MAX); // RL10

    // accepted writes, shared by the settings and the answer so the
    // two can never disagree on what landed
    assign wr_src    = reg_wr && hit_src && src_ok;
    assign wr_pfunc  = reg_wr && hit_pfunc && pfunc_ok;
    assign wr_pscale = reg_wr && hit_pscale && pscale_ok;

    // pulse train measurement
    // the hertz count is left open: only the scaled percentage is used,
    // and a new scaling value applies from the next completed gate
    frs_pulse_meter
    #(
        .GATE_CYCLES (GATE_CYCLES)
    )
    u_meter
    (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .pulse_in   (pulse_input_terminal),
        .full_scale (pulse_input_full_scale),
        .pulse_hz   (),
        .pulse_pct  (pulse_pct),
        .pct_valid  (pct_valid)
    );

    // setting registers; a refused write leaves the old value in place
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            reference_source_select     <= `FRS_SRC_RESET; // RL2
            pulse_input_function_select <= `FRS_PFUNC_RESET; // RL9
            pulse_input_full_scale      <= `FRS_PSCALE_RESET; // RL10
        end
        else
        begin
            // source and function freeze while running; scaling does not
            if (wr_src)
                reference_source_select <= reg_wdata; // RL13
            if (wr_pfunc)
                pulse_input_function_select <= reg_wdata; // RL13
            if (wr_pscale)
                pulse_input_full_scale <= reg_wdata; // RL13
        end
    end

    // register answer: ack on success, err on refused or unmapped access
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 16'h0;
            reg_ack   <= 1'b0;
            reg_err   <= 1'b0;
        end
        else
        begin
            reg_ack <= 1'b0;
            reg_err <= 1'b0;
            // a refused write answers err so the host knows it was dropped
            if (reg_wr)
            begin
                if (wr_src || wr_pfunc || wr_pscale)
                    reg_ack <= 1'b1;
                else
                    reg_err <= 1'b1; // RL13
            end
            else if (reg_rd)
            begin
                if (hit_src)
                begin
                    reg_rdata <= reference_source_select;
                    reg_ack   <= 1'b1;
                end
                else if (hit_pfunc)
                begin
                    reg_rdata <= pulse_input_function_select;
                    reg_ack   <= 1'b1;
                end
                else if (hit_pscale)
                begin
                    reg_rdata <= pulse_input_full_scale;
                    reg_ack   <= 1'b1;
                end
                else
                begin
                    // zero, not stale data, for an unmapped read
                    reg_rdata <= 16'h0;
                    reg_err   <= 1'b1;
                end
            end
        end
    end

    // analog master: second terminal adds to the first when so configured;
    // a current-only master relies on the host holding the first at 0 V
    // saturating instead of wrapping keeps an overdriven pair from
    // folding back to a low speed
    always @*
    begin
        analog_sum = {1'b0, first_analog_terminal}
                     + {1'b0, second_analog_terminal}; // RL5
        if (second_analog_function_select == `FRS_A2_FUNC_ADD)
            analog_ref = analog_sum[16] ? 16'hffff
                                        : analog_sum[15:0]; // RL4
        else
            analog_ref = first_analog_terminal; // RL4
    end

    // master reference from the chosen source
    always @*
    begin
        case (reference_source_select)
            `FRS_SRC_PANEL:  base_ref = panel_freq; // RL3
            `FRS_SRC_ANALOG: base_ref = analog_ref; // RL4
            `FRS_SRC_COMM:   base_ref = comm_freq; // RL1
            `FRS_SRC_OPTION: base_ref = option_freq; // RL1
            `FRS_SRC_PULSE:
                // pulse feeds the reference only in frequency function
                base_ref = (pulse_input_function_select == `FRS_PFUNC_FREQ)
                           ? pulse_pct : 16'h0; // RL8
            // codes above 4 cannot land, but the output stays defined
            default:         base_ref = 16'h0;
        endcase
    end

    // step choice: jog first, then multi-step index
    // aux needs step input 1 alone; with any other input on, the stored
    // table decides, as in the multi-step combinations
    always @*
    begin
        next_step     = {1'b0, multi_step_in};
        next_freq_ref = stored_ref[multi_step_in]; // RL11
        if (jog_select)
        begin
            next_step     = `FRS_JOG_STEP; // RL12
            next_freq_ref = jog_ref; // RL12
        end
        else if (multi_step_in == 4'h0)
            next_freq_ref = base_ref; // RL1
        else if (multi_step_in == 4'h1
                 && third_analog_function_select == `FRS_A3_FUNC_AUX)
            next_freq_ref = third_analog_terminal; // RL6
    end

    // registered outputs
    // one cycle of latency keeps every output straight off a flop
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            freq_ref        <= 16'h0;
            active_step     <= 5'h0;
            a2_current_mode <= 1'b0;
        end
        else
        begin
            freq_ref        <= next_freq_ref;
            active_step     <= next_step;
            a2_current_mode <= (second_analog_level_select
                                == `FRS_A2_LEVEL_CUR); // RL4
        end
    end

    // pid routing of the pulse percentage, updated per measurement
    // values hold between measurements; a function change takes effect
    // at the next completed one
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pid_feedback <= 16'h0;
            pid_target   <= 16'h0;
        end
        else if (pct_valid)
        begin
            if (pulse_input_function_select == `FRS_PFUNC_PID_FB)
                pid_feedback <= pulse_pct; // RL9
            if (pulse_input_function_select == `FRS_PFUNC_PID_TGT)
                pid_target <= pulse_pct; // RL9
        end
    end

endmodule // frs_ref_select

// ==== rtl/frs_defines.vh ====
// frequency reference source select: register map, codes, ranges, timing
// assumes inclusion by bare name from the design files
`ifndef FRS_DEFINES_VH
`define FRS_DEFINES_VH

// register addresses on the drive's serial register protocol
`define FRS_ADDR_SRC        16'h0180
`define FRS_ADDR_PFUNC      16'h042c
`define FRS_ADDR_PSCALE     16'h042d

// reset values
`define FRS_SRC_RESET       16'h0001
`define FRS_PFUNC_RESET     16'h0000
`define FRS_PSCALE_RESET    16'h05a0

// reference source codes
`define FRS_SRC_PANEL       16'h0000
`define FRS_SRC_ANALOG      16'h0001
`define FRS_SRC_COMM        16'h0002
`define FRS_SRC_OPTION      16'h0003
`define FRS_SRC_PULSE       16'h0004
`define FRS_SRC_MAX         16'h0004

// pulse input function codes
`define FRS_PFUNC_FREQ      16'h0000
`define FRS_PFUNC_PID_FB    16'h0001
`define FRS_PFUNC_PID_TGT   16'h0002
`define FRS_PFUNC_MAX       16'h0002

// pulse scaling range in hertz
`define FRS_PSCALE_MIN      16'h03e8
`define FRS_PSCALE_MAX      16'h7d00

// analog terminal configuration codes
`define FRS_A2_FUNC_ADD     5'h00
`define FRS_A3_FUNC_AUX     5'h02
`define FRS_A2_LEVEL_CUR    2'h2

// speed steps: 16 stored references plus jog
`define FRS_STORED_STEPS    16
`define FRS_JOG_STEP        5'h10

// pulse measurement: gate time and clock rate
`define FRS_GATE_MS         1000
`define FRS_CLK_KHZ         100000
`define FRS_PCT_FULL        40'd10000
`define FRS_DIV_BITS        6'd39
`endif

// ==== rtl/frs_pulse_meter.v ====
// pulse train meter: counts rising edges per gate and scales to percent
// assumes pulse_in is synchronous to sys_clk and full_scale is nonzero
`timescale 1ns/10ps
`include "frs_defines.vh"

module frs_pulse_meter
#(
    parameter GATE_CYCLES = `FRS_GATE_MS * `FRS_CLK_KHZ
)
(
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    // pulse terminal and scaling
    input  wire        pulse_in,
    input  wire [15:0] full_scale,
    // results
    output reg  [31:0] pulse_hz,
    output reg  [15:0] pulse_pct,
    output reg         pct_valid
);

    reg         pulse_d;
    reg  [31:0] gate_cnt;
    reg  [31:0] edge_cnt;
    reg  [39:0] dividend;
    reg  [39:0] quo;
    reg  [15:0] rem;
    reg  [15:0] den;
    reg  [5:0]  bit_cnt;
    reg         busy;
    reg         done;
    wire        rise;
    wire [31:0] edge_total;
    wire [16:0] trial;
    wire [39:0] product;

    assign rise       = pulse_in & ~pulse_d;
    assign edge_total = edge_cnt + {31'h0, rise};
    assign trial      = {rem, dividend[39]};
    assign product    = {8'h0, edge_total} * `FRS_PCT_FULL;

    // gate window: with a one second gate the edge count is hertz
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pulse_d  <= 1'b0;
            gate_cnt <= 32'h0;
            edge_cnt <= 32'h0;
            pulse_hz <= 32'h0;
        end
        else
        begin
            pulse_d <= pulse_in;
            if (gate_cnt == GATE_CYCLES - 1)
            begin
                gate_cnt <= 32'h0;
                edge_cnt <= 32'h0;
                pulse_hz <= edge_total;
            end
            else
            begin
                gate_cnt <= gate_cnt + 32'h1;
                edge_cnt <= edge_total;
            end
        end
    end

    // serial restoring divider; slow but one subtractor is all it costs
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            dividend  <= 40'h0;
            quo       <= 40'h0;
            rem       <= 16'h0;
            den       <= 16'h0;
            bit_cnt   <= 6'h0;
            busy      <= 1'b0;
            done      <= 1'b0;
            pulse_pct <= 16'h0;
            pct_valid <= 1'b0;
        end
        else
        begin
            done      <= 1'b0;
            pct_valid <= 1'b0;
            if (!busy && gate_cnt == GATE_CYCLES - 1)
            begin
                dividend <= product;
                quo      <= 40'h0;
                rem      <= 16'h0;
                den      <= full_scale;
                bit_cnt  <= `FRS_DIV_BITS;
                busy     <= 1'b1;
            end
            else if (busy)
            begin
                dividend <= {dividend[38:0], 1'b0};
                if (trial >= {1'b0, den})
                begin
                    rem <= trial[15:0] - den;
                    quo <= {quo[38:0], 1'b1};
                end
                else
                begin
                    rem <= trial[15:0];
                    quo <= {quo[38:0], 1'b0};
                end
                if (bit_cnt == 6'h0)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                else
                    bit_cnt <= bit_cnt - 6'h1;
            end
            // saturate: percent in 0.01 units above 655.35 clips
            if (done)
            begin
                pulse_pct <= (|quo[39:16]) ? 16'hffff : quo[15:0]; // RL10
                pct_valid <= 1'b1;
            end
        end
    end

endmodule // frs_pulse_meter

// ==== dv/frs_ref_select_properties.sv ====
// checker: register answers and reference selection of frs_ref_select
// assumes one clock domain; bound into the design by the bind below
`timescale 1ns/10ps
`include "frs_defines.vh"

module frs_chk
(
    // clock and reset
    input logic        sys_clk,
    input logic        rst,
    // register access
    input logic        reg_wr,
    input logic        reg_rd,
    input logic [15:0] reg_addr,
    input logic [15:0] reg_wdata,
    input logic [15:0] reg_rdata,
    input logic        reg_ack,
    input logic        reg_err,
    input logic        drive_running,
    // selection
    input logic [15:0] third_analog_terminal,
    input logic [1:0]  second_analog_level_select,
    input logic [4:0]  third_analog_function_select,
    input logic [3:0]  multi_step_in,
    input logic        jog_select,
    input logic [15:0] jog_ref,
    input logic [15:0] freq_ref,
    input logic [4:0]  active_step,
    input logic        a2_current_mode
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // decoded conditions used by the properties; aux is shared by two
    wire mapped = reg_addr == `FRS_ADDR_SRC || reg_addr == `FRS_ADDR_PFUNC
                  || reg_addr == `FRS_ADDR_PSCALE;
    wire aux = !jog_select && multi_step_in == 4'h1
               && third_analog_function_select == `FRS_A3_FUNC_AUX;

    // request kinds
    sequence acc_s; reg_wr || reg_rd; endsequence
    sequence src_bad_s; reg_wr && reg_addr == `FRS_ADDR_SRC
        && (drive_running || reg_wdata > `FRS_SRC_MAX); endsequence
    sequence pf_bad_s; reg_wr && reg_addr == `FRS_ADDR_PFUNC
        && (drive_running || reg_wdata > `FRS_PFUNC_MAX); endsequence
    sequence sc_wr_s; reg_wr && reg_addr == `FRS_ADDR_PSCALE; endsequence

    answer_one_a: assert property (acc_s |=> reg_ack != reg_err)
        else $error("access without exactly one answer");
    idle_quiet_a: assert property (!(reg_wr || reg_rd) |=>
        !reg_ack && !reg_err)
        else $error("answer without access");
    unmapped_err_a: assert property ((reg_wr || reg_rd) && !mapped |=>
        reg_err && ($past(reg_wr) || reg_rdata == 16'h0000))
        else $error("unmapped access not refused");
    src_refuse_a: assert property (src_bad_s |=> reg_err)
        else $error("source write not refused");
    pfunc_refuse_a: assert property (pf_bad_s |=> reg_err)
        else $error("pulse function write not refused");
    scale_range_a: assert property (sc_wr_s |=> reg_err ==
        ($past(reg_wdata) < `FRS_PSCALE_MIN
        || $past(reg_wdata) > `FRS_PSCALE_MAX))
        else $error("scaling range check wrong");
    jog_first_a: assert property (jog_select |=> active_step ==
        `FRS_JOG_STEP && freq_ref == $past(jog_ref))
        else $error("jog not given priority");
    aux_third_a: assert property (aux |=>
        freq_ref == $past(third_analog_terminal))
        else $error("auxiliary reference not taken");
    stored_step_a: assert property (!jog_select && multi_step_in != 4'h0
        && !aux |=> active_step == {1'b0, $past(multi_step_in)})
        else $error("step index wrong");
    current_mode_a: assert property (!$past(rst) |-> a2_current_mode ==
        ($past(second_analog_level_select) == `FRS_A2_LEVEL_CUR))
        else $error("current mode flag wrong");
endmodule // frs_chk

bind frs_ref_select frs_chk i_chk (.sys_clk, .rst, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .reg_err, .drive_running,
    .third_analog_terminal, .second_analog_level_select,
    .third_analog_function_select, .multi_step_in, .jog_select, .jog_ref,
    .freq_ref, .active_step, .a2_current_mode);

// ==== dv/frs_host.sv ====
// host model: register accesses and analog terminal configuration
// assumes the bench calls its tasks one access at a time
`timescale 1ns/10ps

module frs_host
(
    // clock
    input  logic        sys_clk,
    // register access
    output logic        reg_wr,
    output logic        reg_rd,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    // analog terminal configuration
    output logic [1:0]  level,
    output logic [4:0]  a2_func,
    output logic [4:0]  a3_func
);
    // idle bus, second terminal adds, third terminal unused
    initial
    begin
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {level, a2_func, a3_func} = {2'h0, 5'h00, 5'h1f};
    end

    // one strobe edge; address and data held through the answer edge
    task acc(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(negedge sys_clk);
        {reg_wr, reg_rd} <= 2'h0;
        @(negedge sys_clk);
        reg_wdata <= ~d; // scrambled once released, so nothing leans on it
    endtask

    // terminal set-up for current master and auxiliary switching
    task cfg(input logic [1:0] l, input logic [4:0] f2, input logic [4:0] f3);
        {level, a2_func, a3_func} = {l, f2, f3};
    endtask
endmodule // frs_host

// ==== dv/frs_ref_select_tb.sv ====
// testbench for frs_ref_select: registers, sources, steps, pulse train
// assumes frs_host drives the register side, the bench the terminals
`timescale 1ns/10ps
`include "frs_defines.vh"

module frs_ref_select_tb;
    logic         sys_clk, rst, run, pin, jog, wr, rd, ack, err, cur;
    logic [15:0]  a1, a2, a3, pan, com, opt, jr, addr, wdata, rdata, x;
    logic [15:0]  fref, pfb, ptg;
    logic [1:0]   lvl;
    logic [4:0]   f2, f3, step;
    logic [3:0]   ms;
    logic [255:0] refs;
    logic [16:0]  s;
    logic [17:0]  q[$];
    logic [17:0]  n;
    int           err_count = 0, check_count = 0, cyc = 0, pc = 0;

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // short gate so a pulse measurement takes about a thousand cycles
    frs_ref_select #(.GATE_CYCLES(1000)) i_dut (.sys_clk(sys_clk),
        .rst(rst), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_ack(ack), .reg_err(err),
        .drive_running(run), .panel_freq(pan), .first_analog_terminal(a1),
        .second_analog_terminal(a2), .third_analog_terminal(a3),
        .comm_freq(com), .option_freq(opt), .pulse_input_terminal(pin),
        .second_analog_level_select(lvl),
        .second_analog_function_select(f2),
        .third_analog_function_select(f3), .multi_step_in(ms),
        .jog_select(jog), .stored_refs(refs), .jog_ref(jr), .freq_ref(fref),
        .active_step(step), .pid_feedback(pfb), .pid_target(ptg),
        .a2_current_mode(cur));

    frs_host i_host (.sys_clk(sys_clk), .reg_wr(wr), .reg_rd(rd),
        .reg_addr(addr), .reg_wdata(wdata), .level(lvl), .a2_func(f2),
        .a3_func(f3));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // note the answer, then let the host make the access
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                       input logic e, input logic [15:0] xd);
        q.push_back({e, !w, xd});
        i_host.acc(w, a, d);
    endtask

    // inputs were set at this falling edge; result lands one edge later
    task automatic sel(input logic [15:0] xf, input logic [4:0] xs);
        @(negedge sys_clk);
        chk(fref, xf);
        chk({11'h0, step}, {11'h0, xs});
    endtask

    task stop_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // answer watcher: oldest note against every register answer
    always @(negedge sys_clk)
        if (ack === 1'b1 || err === 1'b1)
        begin
            n = q.size() ? q.pop_front() : 18'h3ffff;
            chk({15'h0, err}, {15'h0, n[17]});
            if (n[16])
                chk(rdata, n[15:0]);
        end

    // ten-cycle pulse period: any 1000-cycle gate holds exactly 100 edges
    always @(negedge sys_clk)
    begin
        pc = (pc == 9) ? 0 : pc + 1;
        pin <= pc < 5;
    end

    // hang guard, well above the roughly 9000 cycles of the run
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            stop_test();
        end
    end

    initial
    begin
        void'($urandom(32'hbcf3));
        {rst, run, jog, pin, ms, refs} = {3'h4, 1'b0, 4'h0, 256'h0};
        {a1, a2, a3, pan, com, opt, jr} = '0;
        repeat (6) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        acc(0, `FRS_ADDR_SRC, 0, 0, `FRS_SRC_RESET);
        acc(0, `FRS_ADDR_PFUNC, 0, 0, `FRS_PFUNC_RESET);
        acc(0, `FRS_ADDR_PSCALE, 0, 0, `FRS_PSCALE_RESET);
        acc(0, 16'h0181, 0, 1, 16'h0000);
        acc(1, 16'h042e, 1, 1, 0);
        acc(1, `FRS_ADDR_SRC, 16'h0005, 1, 0);
        acc(1, `FRS_ADDR_PFUNC, 16'h0003, 1, 0);
        acc(1, `FRS_ADDR_PSCALE, 16'h03e7, 1, 0);
        acc(1, `FRS_ADDR_PSCALE, 16'h7d01, 1, 0);
        acc(0, `FRS_ADDR_PSCALE, 0, 0, `FRS_PSCALE_RESET);
        acc(1, `FRS_ADDR_PSCALE, `FRS_PSCALE_MAX, 0, 0);
        acc(0, `FRS_ADDR_PSCALE, 0, 0, `FRS_PSCALE_MAX);
        @(negedge sys_clk);
        run = 1'b1;
        acc(1, `FRS_ADDR_SRC, `FRS_SRC_PANEL, 1, 0);
        acc(1, `FRS_ADDR_PFUNC, `FRS_PFUNC_PID_FB, 1, 0);
        acc(1, `FRS_ADDR_PSCALE, `FRS_PSCALE_MIN, 0, 0);
        acc(0, `FRS_ADDR_SRC, 0, 0, `FRS_SRC_RESET);
        @(negedge sys_clk);
        run = 1'b0;
        // sources 0..3, second pass with the second terminal not adding
        for (int i = 0; i < 8; i++)
        begin
            acc(1, `FRS_ADDR_SRC, 16'(i % 4), 0, 0);
            @(negedge sys_clk);
            {a1, a2, pan, com, opt} = 80'({$urandom, $urandom, $urandom});
            i_host.cfg(2'h0, 5'(i / 4), 5'h1f);
            s = a1 + a2;
            x = (i % 4 == 0) ? pan : (i % 4 == 2) ? com : (i % 4 == 3) ? opt
                : (i >= 4) ? a1 : s[16] ? 16'hffff : s[15:0];
            sel(x, 5'h00);
        end
        acc(1, `FRS_ADDR_SRC, `FRS_SRC_ANALOG, 0, 0);
        @(negedge sys_clk);
        a1 = 16'h0000;
        i_host.cfg(`FRS_A2_LEVEL_CUR, `FRS_A2_FUNC_ADD, 5'h1f);
        sel(a2, 5'h00);
        chk({15'h0, cur}, 16'h0001);
        for (int k = 0; k < 8; k++)
            refs[32*k+:32] = $urandom;
        // steps, jog and auxiliary switching on random selections
        for (int i = 0; i < 40; i++)
        begin
            @(negedge sys_clk);
            {ms, a3, jr, a2} = 52'({$urandom, $urandom});
            jog = (i % 5 == 0);
            i_host.cfg(`FRS_A2_LEVEL_CUR, `FRS_A2_FUNC_ADD,
                       i[1] ? `FRS_A3_FUNC_AUX : 5'h1f);
            x = jog ? jr : (ms == 4'h1 && i[1]) ? a3
                : (ms != 4'h0) ? refs[16*ms+:16] : a2;
            sel(x, jog ? `FRS_JOG_STEP : {1'b0, ms});
        end
        @(negedge sys_clk);
        {ms, jog} = 5'h00;
        acc(1, `FRS_ADDR_SRC, `FRS_SRC_PULSE, 0, 0);
        acc(1, `FRS_ADDR_PSCALE, `FRS_PSCALE_MIN, 0, 0);
        repeat (2100) @(negedge sys_clk);
        chk(fref, 16'h03e8);
        run = 1'b1;
        acc(1, `FRS_ADDR_PSCALE, `FRS_PSCALE_MAX, 0, 0);
        repeat (2100) @(negedge sys_clk);
        chk(fref, 16'h001f);
        run = 1'b0;
        acc(1, `FRS_ADDR_PFUNC, `FRS_PFUNC_PID_TGT, 0, 0);
        repeat (2100) @(negedge sys_clk);
        chk(ptg, 16'h001f);
        chk(fref, 16'h0000);
        acc(1, `FRS_ADDR_PFUNC, `FRS_PFUNC_PID_FB, 0, 0);
        repeat (2100) @(negedge sys_clk);
        chk(pfb, 16'h001f);
        rst = 1'b1;
        @(negedge sys_clk);
        rst = 1'b0;
        acc(0, `FRS_ADDR_SRC, 0, 0, `FRS_SRC_RESET);
        repeat (2) @(negedge sys_clk);
        chk(16'(q.size()), 16'h0000);
        stop_test();
    end
endmodule // frs_ref_select_tb
